// [common/pic_map.vh]
// pic_map.vh: constants for the parallel issue checker
// assumes: included by the decoder files, no other dependencies
`ifndef PIC_MAP_VH
`define PIC_MAP_VH
`define PIC_BUNDLE_W    64
`define PIC_WIDE_W      32
`define PIC_NARROW_W    16
`define PIC_CLASS_W     6
`define PIC_WCLS_W      5
`define PIC_LAT_W       4
// wide slot field layout: bits 63:32
`define PIC_WIDE_HI     63
`define PIC_WIDE_LO     32
`define PIC_N1_HI       31
`define PIC_N1_LO       16
`define PIC_N2_HI       15
`define PIC_N2_LO       0
// wide class code sits in the top bits of the wide word
`define PIC_WCLS_HI     31
`define PIC_WCLS_LO     27
// wide variant flag: saturating/accumulator/32-bit form qualifier
`define PIC_WVAR_BIT    26
// narrow class code in the top bits of a 16-bit word
`define PIC_NCLS_HI     15
`define PIC_NCLS_LO     10
// narrow qualifiers: index-register addressing
`define PIC_NIREG_BIT   9
// wide classes
`define WC_MNOP         5'h00
`define WC_ABS          5'h01
`define WC_ADDSUB_SAT   5'h02
`define WC_PRESCALE     5'h03
`define WC_EXP_DETECT   5'h04
`define WC_MAXMIN       5'h05
`define WC_ACC_ONLY     5'h06
`define WC_RND_SAT      5'h07
`define WC_SIGN_COUNT   5'h08
`define WC_BITFIELD     5'h09
`define WC_BIT_MULTIPLEX 5'h0a
`define WC_ONES         5'h0b
`define WC_BIT_XOR      5'h0c
`define WC_MOVE_HALF    5'h0d
`define WC_MOVE_FULL    5'h0e
`define WC_ASHIFT       5'h0f
`define WC_LSHIFT       5'h10
`define WC_ROT          5'h11
`define WC_VECTOR       5'h12
`define WC_MAC          5'h13
`define WC_CMPSEL       5'h14
`define WC_PACKSRCH     5'h15
`define WC_VIDEO        5'h16
// narrow classes
`define NC_NOP          6'h00
`define NC_ADDIMM       6'h01
`define NC_SUBIMM       6'h02
`define NC_MODIFY       6'h03
`define NC_LD_P         6'h04
`define NC_LD_D         6'h05
`define NC_LD_HALF_D    6'h06
`define NC_LD_HW_EXT    6'h07
`define NC_LD_BYTE_EXT  6'h08
`define NC_ST_P         6'h09
`define NC_ST_D         6'h0a
`define NC_ST_HALF_D    6'h0b
`define NC_ST_BYTE      6'h0c
`define NC_ST_P_OFF     6'h0d
// per-class execution latency in cycles
`define LAT_ONE         4'h1
`define LAT_WIDE_MAC    4'h3
`define LAT_WIDE_VIDEO  4'h2
`define LAT_MEM         4'h2
`endif

// [rtl/pic_issue_checker.v]
// pic_issue_checker.v: multi-issue bundle checker and issue stage
// assumes: fetch presents a bundle with a valid strobe and holds it
// while BUNDLE_READY is low; execution accepts one issue unit.
//
// Functional notes
// - bundle is 64 bits: one 32-bit wide slot, two 16-bit slots
// - three members issue as one unit lasting the slowest member
// - a missing second narrow op is filled with the 16-bit nop
// - two narrow ops may pair with the 32-bit nop or any accepted wide op
// - wide slot takes listed arithmetic ops, accumulator-only forms
// - bit fields, bit multiplex, popcount, xor, half moves, 40-bit moves
// - shifts: saturating/accumulator arith, 32-bit logical, rotates
// - vector, multiply/mac, compare-select, pack, search, video ops
// - shift or rotate excludes pointer-plus-offset store
// - first narrow slot from first set, second from second set
// - at most one narrow op is a store
// - two memory ops need at least one index-register form
// - first set: index arith, listed loads and stores
// - second set: index data loads/stores and the 16-bit nop
`timescale 1ns/1ps
`include "pic_map.vh"
module pic_issue_checker
(
    input  wire        MCLK,
    input  wire        RST,
    input  wire [63:0] BUNDLE,
    input  wire        BUNDLE_VALID,
    input  wire        SECOND_EMPTY,
    output reg         BUNDLE_READY,
    output reg  [63:0] ISSUE_WORD,
    output reg         ISSUE_VALID,
    output reg  [3:0]  ISSUE_CYCLES,
    output reg         ILLEGAL
);
    localparam ST_IDLE = 2'b01;
    localparam ST_BUSY = 2'b10;

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [3:0]  count;
    reg  [3:0]  next_count;

    wire [31:0] wide;
    wire [15:0] slot1;
    wire [15:0] slot2;
    wire [4:0]  wcls;
    wire        wvar;
    reg         wide_ok;
    reg         wide_shift;
    reg  [3:0]  wide_lat;

    assign wide  = BUNDLE[`PIC_WIDE_HI:`PIC_WIDE_LO];
    assign slot1 = BUNDLE[`PIC_N1_HI:`PIC_N1_LO];
    // an absent second op becomes the 16-bit nop
    assign slot2 = SECOND_EMPTY ? {`NC_NOP, 10'h000}
                                : BUNDLE[`PIC_N2_HI:`PIC_N2_LO];
    assign wcls  = wide[`PIC_WCLS_HI:`PIC_WCLS_LO];
    assign wvar  = wide[`PIC_WVAR_BIT];

    // for accumulator-only, 40-bit move, arith and logical shift classes a cleared variant bit marks a form the wide slot cannot take
    always @*
    begin
        wide_ok    = 1'b1;
        wide_shift = 1'b0;
        wide_lat   = `LAT_ONE;
        case (wcls)
            `WC_MNOP:
                wide_ok = 1'b1;
            `WC_ABS, `WC_ADDSUB_SAT, `WC_PRESCALE, `WC_EXP_DETECT,
            `WC_MAXMIN, `WC_RND_SAT, `WC_SIGN_COUNT:
                wide_ok = 1'b1;
            `WC_ACC_ONLY:
                wide_ok = wvar;
            `WC_BITFIELD, `WC_BIT_MULTIPLEX, `WC_ONES, `WC_BIT_XOR,
            `WC_MOVE_HALF:
                wide_ok = 1'b1;
            `WC_MOVE_FULL:
                wide_ok = wvar;
            `WC_ASHIFT, `WC_LSHIFT:
            begin
                wide_ok    = wvar;
                wide_shift = 1'b1;
            end
            `WC_ROT:
                wide_shift = 1'b1;
            `WC_VECTOR, `WC_CMPSEL, `WC_PACKSRCH:
                wide_ok = 1'b1;
            `WC_MAC:
                wide_lat = `LAT_WIDE_MAC;
            `WC_VIDEO:
                wide_lat = `LAT_WIDE_VIDEO;
            default:
                wide_ok = 1'b0;
        endcase
    end

    wire       s1_first;
    wire       s1_second;
    wire       s1_store;
    wire       s1_mem;
    wire       s1_ireg;
    wire       s1_poff;
    wire [3:0] s1_lat;
    wire       s2_first;
    wire       s2_second;
    wire       s2_store;
    wire       s2_mem;
    wire       s2_ireg;
    wire       s2_poff;
    wire [3:0] s2_lat;

    // one classifier per narrow slot, both purely combinational
    pic_narrow_class u_slot1
    (
        .insn       (slot1),
        .in_first   (s1_first),
        .in_second  (s1_second),
        .is_store   (s1_store),
        .is_mem     (s1_mem),
        .uses_ireg  (s1_ireg),
        .is_st_poff (s1_poff),
        .lat        (s1_lat)
    );

    pic_narrow_class u_slot2
    (
        .insn       (slot2),
        .in_first   (s2_first),
        .in_second  (s2_second),
        .is_store   (s2_store),
        .is_mem     (s2_mem),
        .uses_ireg  (s2_ireg),
        .is_st_poff (s2_poff),
        .lat        (s2_lat)
    );

    wire slot_ok;
    wire store_ok;
    wire addr_ok;
    wire shift_ok;
    wire legal;
    reg  [3:0] lat_a;
    reg  [3:0] slowest;

    // the first set has no nop, so an empty first slot is refused
    assign slot_ok  = s1_first & s2_second;
    assign store_ok = ~(s1_store & s2_store);
    assign addr_ok  = ~(s1_mem & s2_mem) | s1_ireg | s2_ireg;
    assign shift_ok = ~(wide_shift & (s1_poff | s2_poff));
    assign legal    = wide_ok & slot_ok & store_ok & addr_ok & shift_ok;
    // an illegal bundle never reaches the execution units

    // unit time is the slowest member, not a sum: no superscalar overlap
    always @*
    begin
        lat_a = s2_lat;
        if (s1_lat > s2_lat)
            lat_a = s1_lat;
        slowest = lat_a;
        if (wide_lat > lat_a)
            slowest = wide_lat;
    end

    wire take;
    // ready gates the take: the first cycle after reset takes nothing
    assign take = (state == ST_IDLE) & BUNDLE_READY & BUNDLE_VALID;

    always @*
    begin
        next_state = state;
        next_count = count;
        case (state)
            ST_IDLE:
            begin
                if (take && legal && slowest > `LAT_ONE)
                begin
                    next_state = ST_BUSY;
                    next_count = slowest - `LAT_ONE;
                end
            end
            ST_BUSY:
            begin
                next_count = count - `LAT_ONE;
                // ready rises at the edge that ends the last busy cycle, together with the return to idle
                if (count == `LAT_ONE)
                    next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
                next_count = 4'h0;
            end
        endcase
    end

    always @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state        <= ST_IDLE;
            count        <= 4'h0;
            BUNDLE_READY <= 1'b0;
            ISSUE_WORD   <= 64'h0000000000000000;
            ISSUE_VALID  <= 1'b0;
            ISSUE_CYCLES <= 4'h0;
            ILLEGAL      <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            count        <= next_count;
            ISSUE_VALID  <= take & legal;
            ILLEGAL      <= take & ~legal;
            BUNDLE_READY <= (next_state == ST_IDLE);
            // word and length hold until the next legal issue
            if (take && legal)
            begin
                ISSUE_WORD   <= {wide, slot1, slot2};
                ISSUE_CYCLES <= slowest;
            end
        end
    end
endmodule // pic_issue_checker

// [rtl/pic_narrow_class.v]
// pic_narrow_class.v: classifies one 16-bit slot of a bundle
// assumes: purely combinational, driven from the bundle register
`timescale 1ns/1ps
`include "pic_map.vh"
module pic_narrow_class
(
    input  wire [15:0] insn,
    output reg         in_first,
    output reg         in_second,
    output reg         is_store,
    output reg         is_mem,
    output reg         uses_ireg,
    output reg         is_st_poff,
    output reg  [3:0]  lat
);
    wire [5:0] cls;
    wire       ireg;
    assign cls  = insn[`PIC_NCLS_HI:`PIC_NCLS_LO];
    assign ireg = insn[`PIC_NIREG_BIT];
    always @*
    begin
        in_first   = 1'b0;
        in_second  = 1'b0;
        is_store   = 1'b0;
        is_mem     = 1'b0;
        uses_ireg  = ireg;
        is_st_poff = 1'b0;
        lat        = `LAT_ONE;
        case (cls)
            `NC_NOP:
            begin
                in_second = 1'b1;
                uses_ireg = 1'b0;
            end
            `NC_ADDIMM, `NC_SUBIMM, `NC_MODIFY:
                in_first = ireg;
            `NC_LD_P, `NC_LD_HW_EXT, `NC_LD_BYTE_EXT:
            begin
                in_first = 1'b1;
                is_mem   = 1'b1;
                lat      = `LAT_MEM;
            end
            `NC_LD_D, `NC_LD_HALF_D:
            begin
                in_first  = 1'b1;
                in_second = ireg;
                is_mem    = 1'b1;
                lat       = `LAT_MEM;
            end
            `NC_ST_P, `NC_ST_BYTE:
            begin
                in_first = 1'b1;
                is_mem   = 1'b1;
                is_store = 1'b1;
            end
            `NC_ST_D, `NC_ST_HALF_D:
            begin
                in_first  = 1'b1;
                in_second = ireg;
                is_mem    = 1'b1;
                is_store  = 1'b1;
            end
            `NC_ST_P_OFF:
            begin
                // pointer plus offset store is a first-set store, never an index form
                in_first   = 1'b1;
                is_mem     = 1'b1;
                is_store   = 1'b1;
                uses_ireg  = 1'b0;
                is_st_poff = 1'b1;
            end
            default:
            begin
                in_first  = 1'b0;
                in_second = 1'b0;
            end
        endcase
    end
endmodule // pic_narrow_class

// [tb/pic_fetch_model.sv]
// pic_fetch_model.sv: behavioural fetch unit offering bundles
// assumes: a bundle is taken on an edge where ready is high
`timescale 1ns/1ps
module pic_fetch_model
(
    input  wire        MCLK,
    input  wire        ready,
    output reg  [63:0] bundle,
    output reg         valid,
    output reg         second_empty
);
    initial
    begin
        bundle = 64'h0;
        valid = 1'b0;
        second_empty = 1'b0;
    end
    // called just after an edge; request stays up after the take so
    // the next offer can follow in the same cycle
    task offer(input [63:0] word, input se);
    begin
        bundle = word;
        second_empty = se;
        valid = 1'b1;
        while (ready !== 1'b1)
        begin
            @(posedge MCLK);
            #1;
        end
        @(posedge MCLK);
        #1;
    end
    endtask
    // inverted word after release so a stale bundle is never reused
    task idle;
    begin
        valid = 1'b0;
        bundle = ~bundle;
    end
    endtask
endmodule // pic_fetch_model

// [tb/pic_issue_checker_properties.sv]
// pic_issue_checker_properties.sv: port-level checks of the issue stage
// assumes: bound to pic_issue_checker, sees its ports only
`timescale 1ns/1ps
module pic_issue_props
(
    input wire        MCLK,
    input wire        RST,
    input wire [63:0] BUNDLE,
    input wire        BUNDLE_VALID,
    input wire        SECOND_EMPTY,
    input wire        BUNDLE_READY,
    input wire [63:0] ISSUE_WORD,
    input wire        ISSUE_VALID,
    input wire [3:0]  ISSUE_CYCLES,
    input wire        ILLEGAL
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    wire take = BUNDLE_VALID && BUNDLE_READY;
    chk_answer_next: assert property (
        take |=> ISSUE_VALID ^ ILLEGAL) else $error("no answer");
    chk_no_stray: assert property (
        ISSUE_VALID || ILLEGAL |-> $past(take)) else $error("stray answer");
    chk_word_copy: assert property (
        ISSUE_VALID && !$past(SECOND_EMPTY) |-> ISSUE_WORD == $past(BUNDLE))
        else $error("issued word differs");
    chk_nop_fill: assert property (
        ISSUE_VALID && $past(SECOND_EMPTY) |-> ISSUE_WORD[15:0] == 16'h0000)
        else $error("empty slot not filled");
    chk_mac_busy: assert property (
        ISSUE_VALID && ISSUE_CYCLES == 4'h3 |->
        !BUNDLE_READY ##1 !BUNDLE_READY ##1 BUNDLE_READY)
        else $error("busy time wrong");
    chk_one_store: assert property (
        ISSUE_VALID |-> !(ISSUE_WORD[31:26] inside {[6'h09:6'h0d]} &&
        ISSUE_WORD[15:10] inside {6'h0a, 6'h0b})) else $error("two stores");
    chk_first_set: assert property (
        ISSUE_VALID |-> ISSUE_WORD[31:26] inside {[6'h01:6'h0d]})
        else $error("first slot class");
    chk_ill_ready: assert property (
        ILLEGAL |-> BUNDLE_READY && $stable(ISSUE_WORD))
        else $error("reject disturbed state");
    chk_index_form: assert property (
        ISSUE_VALID && ISSUE_WORD[15:10] inside {6'h05, 6'h06, 6'h0a, 6'h0b}
        |-> ISSUE_WORD[9])
        else $error("second slot memory op lacks index form");
    cover property (ILLEGAL);
    cover property (ISSUE_VALID && ISSUE_CYCLES == 4'h3);
    cover property (take && SECOND_EMPTY);
endmodule // pic_issue_props
bind pic_issue_checker pic_issue_props u_props (.MCLK(MCLK), .RST(RST),
    .BUNDLE(BUNDLE), .BUNDLE_VALID(BUNDLE_VALID),
    .SECOND_EMPTY(SECOND_EMPTY), .BUNDLE_READY(BUNDLE_READY),
    .ISSUE_WORD(ISSUE_WORD), .ISSUE_VALID(ISSUE_VALID),
    .ISSUE_CYCLES(ISSUE_CYCLES), .ILLEGAL(ILLEGAL));

// [tb/tb.sv]
// tb.sv: self-checking bench for the parallel issue checker
// assumes: fetch model drives bundles, outputs are read directly
`timescale 1ns/1ps
module tb;
    reg         MCLK;
    reg         RST;
    wire [63:0] bundle;
    wire        valid;
    wire        second_empty;
    wire        ready;
    wire [63:0] issue_word;
    wire        issue_valid;
    wire [3:0]  issue_cycles;
    wire        illegal;
    integer     bad_count = 0;
    integer     n_tests = 0;
    integer     cyc = 0;
    integer     i;
    localparam [15:0] addi = 16'h0600;
    localparam [31:0] abs_w = 32'h08000000;
    pic_issue_checker DUT (.MCLK(MCLK), .RST(RST), .BUNDLE(bundle),
        .BUNDLE_VALID(valid), .SECOND_EMPTY(second_empty),
        .BUNDLE_READY(ready), .ISSUE_WORD(issue_word),
        .ISSUE_VALID(issue_valid), .ISSUE_CYCLES(issue_cycles),
        .ILLEGAL(illegal));
    pic_fetch_model fetch (.MCLK(MCLK), .ready(ready), .bundle(bundle),
        .valid(valid), .second_empty(second_empty));
    initial
    begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end
    // about 70 bundles of at most 3 cycles; ceiling leaves headroom
    always @(posedge MCLK)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            bad_count = bad_count + 1;
            results;
        end
    end
    function [31:0] wop(input [4:0] cls, input vb);
        wop = {cls, vb, 26'h0};
    endfunction
    task send(input [31:0] w, input [15:0] a, input [15:0] b, input se,
              input ok, input [3:0] cy);
        reg [67:0] exp;
    begin
        exp = {w, a, se ? 16'h0 : b, cy};
        fetch.offer({w, a, b}, se);
        n_tests = n_tests + 1;
        if (issue_valid !== ok || illegal !== !ok)
        begin
            bad_count = bad_count + 1;
            $display("unexpected verdict expected %b seen %b", ok,
                     issue_valid);
        end
        else if (ok && {issue_word, issue_cycles} !== exp)
        begin
            bad_count = bad_count + 1;
            $display("unexpected issue expected %h seen %h", exp,
                     {issue_word, issue_cycles});
        end
    end
    endtask
    task t_wide_slot;
    begin
        for (i = 0; i < 32; i = i + 1)
            send(wop(i[4:0], i == 6 || (i > 13 && i < 17)), addi,
                 16'h0, 1'b0, i < 23,
                 (i == 19) ? 4'h3 : (i == 22) ? 4'h2 : 4'h1);
        for (i = 0; i < 4; i = i + 1)
            send(wop(i == 0 ? 5'h06 : 5'h0d + i[4:0], 1'b0), addi,
                 16'h0, 1'b0, 1'b0, 4'h0);
    end
    endtask
    task t_shift_store;
    begin
        send(wop(5'h0f, 1'b1), 16'h3400, 16'h0, 1'b0, 1'b0, 4'h0);
        send(wop(5'h11, 1'b0), 16'h3400, 16'h0, 1'b0, 1'b0, 4'h0);
        send(wop(5'h13, 1'b0), 16'h3400, 16'h0, 1'b0, 1'b1, 4'h3);
        send(wop(5'h10, 1'b1), addi, 16'h0, 1'b0, 1'b1, 4'h1);
    end
    endtask
    task t_first_set;
    begin
        for (i = 1; i < 16; i = i + 1)
            send(abs_w, {i[5:0], i != 13, 9'h0}, 16'h0, 1'b0, i < 14,
                 (i > 3 && i < 9) ? 4'h2 : 4'h1);
        send(abs_w, 16'h0000, 16'h0, 1'b0, 1'b0, 4'h0);
        send(abs_w, 16'h0c00, 16'h0, 1'b0, 1'b0, 4'h0);
        send(abs_w, 16'h3600, 16'h0, 1'b0, 1'b1, 4'h1);
    end
    endtask
    task t_second_set;
    begin
        send(abs_w, addi, 16'h1600, 1'b0, 1'b1, 4'h2);
        send(abs_w, addi, 16'h1a00, 1'b0, 1'b1, 4'h2);
        send(abs_w, addi, 16'h2e00, 1'b0, 1'b1, 4'h1);
        send(abs_w, addi, 16'h1400, 1'b0, 1'b0, 4'h0);
        send(abs_w, addi, addi, 1'b0, 1'b0, 4'h0);
    end
    endtask
    task t_memory_pairs;
    begin
        send(abs_w, 16'h2a00, 16'h2e00, 1'b0, 1'b0, 4'h0);
        send(abs_w, 16'h3400, 16'h2a00, 1'b0, 1'b0, 4'h0);
        send(abs_w, 16'h3000, 16'h1a00, 1'b0, 1'b1, 4'h2);
        send(abs_w, 16'h1400, 16'h1600, 1'b0, 1'b1, 4'h2);
        send(32'h0, 16'h2000, 16'hffff, 1'b1, 1'b1, 4'h2);
        send(32'h0, addi, 16'h2a00, 1'b0, 1'b1, 4'h1);
    end
    endtask
    task results;
    begin
        $display("mismatches %0d of %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    initial
    begin
        RST = 1'b1;
        repeat (16) @(posedge MCLK);
        #1;
        RST = 1'b0;
        t_wide_slot;
        t_shift_store;
        t_first_set;
        t_second_set;
        t_memory_pairs;
        fetch.idle;
        repeat (4) @(posedge MCLK);
        results;
    end
endmodule // tb
